//--- rtl/dtm_pkg.sv
// Shared constants and types of the data mover
package dtm_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DESC_N = 4;
  localparam int IDX_W = 2;
  localparam int PTR_W = 24;
  localparam int DAT_W = 16;
  localparam int CFG_W = 11;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low eight bits of haddr)
  // ----------------------------------------------------------------
  localparam logic [7:0] DESC_SPAN = 8'h40;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_SRC = 4'h4;
  localparam logic [3:0] OFS_DST = 4'h8;
  localparam logic [3:0] OFS_CNT = 4'hC;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_STAT = 8'h44;
  localparam logic [7:0] ADDR_IRQ = 8'h48;
  localparam logic [7:0] ADDR_MASK = 8'h4C;

  // ----------------------------------------------------------------
  // Descriptor configuration, control and status fields
  // ----------------------------------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_WORD_BIT = 2;
  localparam int CFG_SRC_LSB = 3;
  localparam int CFG_DST_LSB = 5;
  localparam int CFG_BLKDST_BIT = 7;
  localparam int CFG_CHAIN_BIT = 8;
  localparam int CFG_IRQEN_BIT = 9;
  localparam int CFG_ARMED_BIT = 10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SW_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CUR_LSB = 1;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [PTR_W-1:0] STEP_BYTE = 24'h00_0001;
  localparam logic [PTR_W-1:0] STEP_WORD = 24'h00_0002;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] RST_CFG = 11'h000;
  localparam logic [PTR_W-1:0] RST_PTR = 24'h00_0000;
  localparam logic [DAT_W-1:0] RST_CNT = 16'h0001;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LOAD  = 5'b00010,
    ST_READ  = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_WBACK = 5'b10000
  } dtm_state_t;
endpackage

//--- rtl/dtm_step.sv
// Pointer stepper of the data mover
`timescale 1ns/10ps
`default_nettype none
module dtm_step
  import dtm_pkg::*;
(
  input wire logic [PTR_W-1:0] ptr,
  input wire logic [1:0] step,
  input wire logic word,
  output logic [PTR_W-1:0] nxt_ptr
);
  wire [PTR_W-1:0] delta = word ? STEP_WORD : STEP_BYTE;
  // Code 3 holds, like code 0
  assign nxt_ptr = (step == STEP_INC) ? ptr + delta :
                   (step == STEP_DEC) ? ptr - delta : ptr;
endmodule // dtm_step
`default_nettype wire

//--- rtl/dtm_engine.sv
// Data mover: descriptors, AHB-Lite registers, transfer engine
// Operation
// - Three transfer modes per descriptor: normal, repeat, block.
// - Each descriptor holds a 24-bit source and destination pointer.
// - After every transfer each pointer steps up, down or holds on its own.
// - A step is 1 for bytes and 2 for words.
// - Normal mode moves one unit per activation, count 1 to 65,536.
// - Normal mode may raise an enabled interrupt when the count ends.
// - Repeat mode moves one unit per activation, count 1 to 256.
// - Repeat mode reloads initial pointers and count at the end, then goes on.
// - Repeat mode never raises an end-of-count interrupt.
// - Block mode moves one block of 1 to 256 units per activation.
// - Block mode treats either source or destination as the block area.
// - After a block the block-side pointer returns to its start; other steps on.
// - Block count is 1 to 65,536 and may raise an interrupt at the end.
// - One activation runs the descriptor plus each following chained one.
// - Block size is the initial high and low count, fixing reads and writes.
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module dtm_engine
  import dtm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [DESC_N-1:0] act_req,
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [PTR_W-1:0] mem_addr,
  output logic [DAT_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DAT_W-1:0] mem_rdata,
  output logic irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DESC_N-1:0] onehot(input logic [IDX_W-1:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction

  function automatic logic [IDX_W-1:0] lowest(input logic [DESC_N-1:0] req);
    lowest = '0;
    for (int i = DESC_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        lowest = IDX_W'(i);
      end
    end
  endfunction

  // Zero in a count field means the largest count
  function automatic logic last8(input logic [7:0] cnt);
    last8 = (cnt == 8'h01);
  endfunction

  function automatic logic last16(input logic [15:0] cnt);
    last16 = (cnt == 16'h0001);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_ff [DESC_N];
  logic [PTR_W-1:0] src_ff [DESC_N];
  logic [PTR_W-1:0] dst_ff [DESC_N];
  logic [PTR_W-1:0] isrc_ff [DESC_N];
  logic [PTR_W-1:0] idst_ff [DESC_N];
  logic [DAT_W-1:0] cnta_ff [DESC_N];
  logic [DAT_W-1:0] cntb_ff [DESC_N];

  logic ap_valid_ff, ap_write_ff, hreadyout_ff;
  logic [7:0] ap_addr_ff;
  logic [31:0] hrdata_ff;
  logic enable_ff, irq_ff;
  logic [DESC_N-1:0] pend_ff, irq_stat_ff, irq_mask_ff;

  dtm_state_t state_ff;
  logic [IDX_W-1:0] cur_ff, head_ff;
  logic [CFG_W-1:0] w_cfg_ff;
  logic [PTR_W-1:0] w_src_ff, w_dst_ff;
  logic [DAT_W-1:0] w_cnta_ff, w_cntb_ff, data_ff;
  logic end_ff;
  logic mem_req_ff, mem_we_ff;
  logic [PTR_W-1:0] mem_addr_ff;

  // ----------------------------------------------------------------
  // AHB-Lite slave decode
  // ----------------------------------------------------------------
  // One wait state per transfer so read data leaves a flip-flop
  wire accept = hsel & hready & htrans[1];
  wire bus_wr = ap_valid_ff & ap_write_ff;
  wire desc_hit = ap_addr_ff < DESC_SPAN;
  wire [IDX_W-1:0] b_idx = ap_addr_ff[5:4];
  wire [3:0] b_ofs = ap_addr_ff[3:0];
  wire wr_desc = bus_wr & desc_hit;
  wire wr_ctrl = bus_wr & (ap_addr_ff == ADDR_CTRL);
  wire wr_irq = bus_wr & (ap_addr_ff == ADDR_IRQ);
  wire wr_mask = bus_wr & (ap_addr_ff == ADDR_MASK);
  wire [DESC_N-1:0] sw_trig = wr_ctrl ? hwdata[CTRL_SW_LSB +: DESC_N] : '0;
  wire busy = ~state_ff[0];

  wire [31:0] rd_desc =
    (b_ofs == OFS_CFG) ? {21'h00_0000, cfg_ff[b_idx]} :
    (b_ofs == OFS_SRC) ? {8'h00, src_ff[b_idx]} :
    (b_ofs == OFS_DST) ? {8'h00, dst_ff[b_idx]} :
    (b_ofs == OFS_CNT) ? {cntb_ff[b_idx], cnta_ff[b_idx]} : RST_WORD;
  wire [31:0] rd_ctrl = {24'h00_0000, pend_ff, 3'h0, enable_ff};
  wire [31:0] rd_stat = {29'h0000_0000, cur_ff, busy};
  wire [31:0] rd_word =
    desc_hit ? rd_desc :
    (ap_addr_ff == ADDR_CTRL) ? rd_ctrl :
    (ap_addr_ff == ADDR_STAT) ? rd_stat :
    (ap_addr_ff == ADDR_IRQ) ? {28'h000_0000, irq_stat_ff} :
    (ap_addr_ff == ADDR_MASK) ? {28'h000_0000, irq_mask_ff} : RST_WORD;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= RST_WORD;
    end else begin
      ap_valid_ff <= accept;
      hreadyout_ff <= ~accept;
      if (accept) begin
        ap_write_ff <= hwrite;
        ap_addr_ff <= haddr[7:0];
      end
      if (ap_valid_ff) begin
        hrdata_ff <= ap_write_ff ? RST_WORD : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Working transfer arithmetic
  // ----------------------------------------------------------------
  wire [1:0] w_mode = w_cfg_ff[CFG_MODE_LSB +: 2];
  wire w_word = w_cfg_ff[CFG_WORD_BIT];
  wire is_rep = (w_mode == MODE_REPEAT);
  wire is_blk = (w_mode == MODE_BLOCK);
  wire blk_dst = w_cfg_ff[CFG_BLKDST_BIT];
  wire [7:0] cnt_hi = w_cnta_ff[15:8];
  wire [7:0] cnt_lo = w_cnta_ff[7:0];
  wire lo_last = last8(cnt_lo);
  wire [PTR_W-1:0] step_src, step_dst;

  dtm_step u_step_src (
    .ptr(w_src_ff),
    .step(w_cfg_ff[CFG_SRC_LSB +: 2]),
    .word(w_word),
    .nxt_ptr(step_src)
  );

  dtm_step u_step_dst (
    .ptr(w_dst_ff),
    .step(w_cfg_ff[CFG_DST_LSB +: 2]),
    .word(w_word),
    .nxt_ptr(step_dst)
  );

  wire rep_wrap = is_rep & lo_last;
  wire blk_wrap = is_blk & lo_last;
  wire [PTR_W-1:0] nxt_src = (rep_wrap | (blk_wrap & ~blk_dst)) ? isrc_ff[cur_ff] : step_src;
  wire [PTR_W-1:0] nxt_dst = (rep_wrap | (blk_wrap & blk_dst)) ? idst_ff[cur_ff] : step_dst;
  wire [7:0] nxt_lo = lo_last ? cnt_hi : cnt_lo - 8'h01;
  wire [DAT_W-1:0] nxt_cnta = (is_rep | is_blk) ? {cnt_hi, nxt_lo} : w_cnta_ff - 16'h0001;
  wire [DAT_W-1:0] nxt_cntb = blk_wrap ? w_cntb_ff - 16'h0001 : w_cntb_ff;
  wire nxt_end = is_blk ? (lo_last & last16(w_cntb_ff)) : (~is_rep & last16(w_cnta_ff));
  wire blk_more = is_blk & ~lo_last;

  wire chain_go = w_cfg_ff[CFG_CHAIN_BIT] & (cur_ff != IDX_W'(DESC_N - 1));
  wire chain_done = state_ff[4] & ~chain_go;
  wire ev_end = state_ff[4] & end_ff & w_cfg_ff[CFG_IRQEN_BIT] & ~is_rep;

  wire [DESC_N-1:0] armed;
  for (genvar g = 0; g < DESC_N; g++) begin : g_arm
    assign armed[g] = cfg_ff[g][CFG_ARMED_BIT];
  end

  // ----------------------------------------------------------------
  // Descriptor store: engine write-back wins over the bus
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < DESC_N; i++) begin
        cfg_ff[i] <= RST_CFG;
        src_ff[i] <= RST_PTR;
        dst_ff[i] <= RST_PTR;
        isrc_ff[i] <= RST_PTR;
        idst_ff[i] <= RST_PTR;
        cnta_ff[i] <= RST_CNT;
        cntb_ff[i] <= RST_CNT;
      end
    end else if (state_ff[4]) begin
      src_ff[cur_ff] <= w_src_ff;
      dst_ff[cur_ff] <= w_dst_ff;
      cnta_ff[cur_ff] <= w_cnta_ff;
      cntb_ff[cur_ff] <= w_cntb_ff;
      if (end_ff && !is_rep) begin
        cfg_ff[cur_ff][CFG_ARMED_BIT] <= 1'b0;
      end
    end else if (wr_desc) begin
      case (b_ofs)
        OFS_CFG: cfg_ff[b_idx] <= hwdata[CFG_W-1:0];
        OFS_SRC: begin
          src_ff[b_idx] <= hwdata[PTR_W-1:0];
          isrc_ff[b_idx] <= hwdata[PTR_W-1:0];
        end
        OFS_DST: begin
          dst_ff[b_idx] <= hwdata[PTR_W-1:0];
          idst_ff[b_idx] <= hwdata[PTR_W-1:0];
        end
        OFS_CNT: begin
          cnta_ff[b_idx] <= hwdata[15:0];
          cntb_ff[b_idx] <= hwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control, activation and interrupt
  // ----------------------------------------------------------------
  wire [DESC_N-1:0] pend_set = (act_req & armed) | sw_trig;
  wire [DESC_N-1:0] pend_clr = chain_done ? onehot(head_ff) : '0;
  // Activation in the clearing cycle survives
  wire [DESC_N-1:0] nxt_pend = (pend_ff & ~pend_clr) | pend_set;
  wire [DESC_N-1:0] irq_clr = wr_irq ? hwdata[DESC_N-1:0] : '0;
  wire [DESC_N-1:0] irq_set = ev_end ? onehot(cur_ff) : '0;
  wire [DESC_N-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_ff <= 1'b0;
      pend_ff <= '0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_ff <= hwdata[CTRL_EN_BIT];
      end
      if (wr_mask) begin
        irq_mask_ff <= hwdata[DESC_N-1:0];
      end
      pend_ff <= nxt_pend;
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      head_ff <= '0;
      w_cfg_ff <= RST_CFG;
      w_src_ff <= RST_PTR;
      w_dst_ff <= RST_PTR;
      w_cnta_ff <= RST_CNT;
      w_cntb_ff <= RST_CNT;
      data_ff <= '0;
      end_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= RST_PTR;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (enable_ff && (pend_ff != '0)) begin
            head_ff <= lowest(pend_ff);
            cur_ff <= lowest(pend_ff);
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          w_cfg_ff <= cfg_ff[cur_ff];
          w_src_ff <= src_ff[cur_ff];
          w_dst_ff <= dst_ff[cur_ff];
          w_cnta_ff <= cnta_ff[cur_ff];
          w_cntb_ff <= cntb_ff[cur_ff];
          end_ff <= 1'b0;
          mem_req_ff <= 1'b1;
          mem_we_ff <= 1'b0;
          mem_addr_ff <= src_ff[cur_ff];
          state_ff <= ST_READ;
        end
        ST_READ: begin
          if (mem_ack) begin
            data_ff <= mem_rdata;
            mem_we_ff <= 1'b1;
            mem_addr_ff <= w_dst_ff;
            state_ff <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            w_src_ff <= nxt_src;
            w_dst_ff <= nxt_dst;
            w_cnta_ff <= nxt_cnta;
            w_cntb_ff <= nxt_cntb;
            end_ff <= nxt_end;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= nxt_src;
            mem_req_ff <= blk_more;
            state_ff <= blk_more ? ST_READ : ST_WBACK;
          end
        end
        ST_WBACK: begin
          if (chain_go) begin
            cur_ff <= cur_ff + IDX_W'(1);
            state_ff <= ST_LOAD;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          mem_req_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_word = w_cfg_ff[CFG_WORD_BIT];
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = data_ff;
  assign irq = irq_ff;
endmodule // dtm_engine
`default_nettype wire

//--- bench/dtm_mem.sv
// Memory partner of the data mover, counting the writes it takes
`timescale 1ns/10ps
`default_nettype none
module dtm_mem
  import dtm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [PTR_W-1:0] mem_addr,
  input wire logic [DAT_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [DAT_W-1:0] mem_rdata,
  output logic [15:0] n_wr,
  output logic [PTR_W-1:0] last_wa,
  output logic [DAT_W-1:0] last_wd,
  input wire logic mem_word,
  output logic last_ww
);
  // ------------------------------------------------------------
  // Answer logic
  // ------------------------------------------------------------
  logic [1:0] wait_ff;
  wire logic [DAT_W-1:0] pat = mem_addr[15:0] ^ 16'h5A5A;
  // Inverse outside the ack cycle, so a late capture shows up
  assign mem_rdata = mem_ack ? pat : ~pat;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'b00;
      n_wr <= 16'h0000;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_ff <= slow ? 2'b10 : 2'b00;
      if (mem_we) begin
        n_wr <= n_wr + 16'h0001;
        last_wa <= mem_addr;
        last_wd <= mem_wdata;
        last_ww <= mem_word;
      end
    end else if (mem_req && wait_ff == 2'b00) begin
      mem_ack <= 1'b1;
    end else if (mem_req) begin
      wait_ff <= wait_ff - 2'b01;
    end
  end
endmodule // dtm_mem
`default_nettype wire

//--- bench/dtm_checker.sv
// Port checker of the data mover
`timescale 1ns/10ps
`default_nettype none
module dtm_checker
  import dtm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [PTR_W-1:0] mem_addr,
  input wire logic [DAT_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DAT_W-1:0] mem_rdata
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic taken = hsel && hready && htrans[1];
  a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_wait_short: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_write_rdata: assert property (taken && hwrite |=> ##1 hrdata == 32'h0000_0000)
    else $error("read data not zero after write");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_word))
    else $error("memory request changed before ack");
  a_data_pass: assert property (mem_req && mem_ack && !mem_we |=> mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("read data not passed to write");
  a_read_first: assert property ($rose(mem_req) |-> !mem_we)
    else $error("activation did not start with a read");
  a_write_next: assert property (mem_req && mem_ack && mem_we |=> !mem_req || !mem_we)
    else $error("write not followed by read or release");
endmodule // dtm_checker
`default_nettype wire

//--- bench/data_transfer_mode_engine_test.sv
// Self-checking bench of the data mover
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module data_transfer_mode_engine_test;
  import dtm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [DESC_N-1:0] act_req = 4'h0;
  logic slow = 1'b0;
  logic hready, hreadyout, hresp, mem_req, mem_we, mem_word, mem_ack, irq, last_ww;
  logic [31:0] hrdata, r;
  logic [PTR_W-1:0] mem_addr, last_wa;
  logic [DAT_W-1:0] mem_wdata, mem_rdata, last_wd;
  logic [15:0] n_wr, wr0;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  assign hready = hreadyout;
  always #20 clock = ~clock;
  dtm_engine DUT (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .act_req, .mem_req, .mem_we, .mem_word, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .irq);
  dtm_mem u_mem (.clock, .rst_n, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .n_wr, .last_wa, .last_wd, .mem_word, .last_ww);
  // ------------------------------------------------------------
  // Bus and activation tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(r, e)
  endtask
  task automatic desc(input logic [1:0] i, input logic [31:0] c, s, d, n);
    wr({2'b00, i, OFS_CFG}, c);
    wr({2'b00, i, OFS_SRC}, s);
    wr({2'b00, i, OFS_DST}, d);
    wr({2'b00, i, OFS_CNT}, n);
  endtask
  // Pending is seen only a few edges later, so polling waits first
  task automatic idle();
    repeat (3) @(posedge clock);
    do
      bus(1'b0, ADDR_STAT, 32'h0000_0000);
    while (r[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic fire(input int i);
    act_req[i] <= 1'b1;
    @(posedge clock);
    act_req[i] <= 1'b0;
    idle();
  endtask
  task automatic gap();
    repeat (2) @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rc(8'h0C, 32'h0001_0001);
    rc(8'h00, 32'h0000_0000);
    rc(8'h50, 32'h0000_0000);
    rc(ADDR_IRQ, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_000F);
    $display("test reset done");
    desc(2'd0, 32'h0000_064C, 32'h0000_1000, 32'h0000_2000, 32'h0000_0002);
    fire(0);
    `CHK(last_wa, 24'h00_2000)
    `CHK(last_wd, 16'h4A5A)
    `CHK(last_ww, 1'b1)
    rc(8'h04, 32'h0000_1002);
    rc(8'h08, 32'h0000_1FFE);
    rc(8'h0C, 32'h0000_0001);
    `CHK(irq, 1'b0)
    fire(0);
    `CHK(last_wa, 24'h00_1FFE)
    `CHK(irq, 1'b1)
    rc(ADDR_IRQ, 32'h0000_0001);
    rc(8'h00, 32'h0000_024C);
    wr0 = n_wr;
    fire(0);
    `CHK(n_wr, wr0)
    wr(ADDR_IRQ, 32'h0000_0001);
    gap();
    `CHK(irq, 1'b0)
    $display("test normal done");
    desc(2'd1, 32'h0000_0621, 32'h0000_0030, 32'h0000_0040, 32'h0000_0202);
    wr0 = n_wr;
    for (int k = 0; k < 3; k++) fire(1);
    `CHK(n_wr, wr0 + 16'h0003)
    `CHK(last_wa, 24'h00_0040)
    `CHK(last_wd, 16'h5A6A)
    `CHK(last_ww, 1'b0)
    rc(8'h18, 32'h0000_0041);
    rc(8'h1C, 32'h0000_0201);
    `CHK(irq, 1'b0)
    rc(ADDR_IRQ, 32'h0000_0000);
    $display("test repeat done");
    slow <= 1'b1;
    desc(2'd2, 32'h0000_07AA, 32'h0000_0100, 32'h0000_0200, 32'h0001_0202);
    desc(2'd3, 32'h0000_0404, 32'h0000_0300, 32'h0000_0400, 32'h0000_0001);
    wr0 = n_wr;
    wr(ADDR_CTRL, 32'h0000_0041);
    idle();
    `CHK(n_wr, wr0 + 16'h0003)
    `CHK(last_wa, 24'h00_0400)
    `CHK(last_wd, 16'h595A)
    `CHK(last_ww, 1'b1)
    rc(8'h24, 32'h0000_0102);
    rc(8'h28, 32'h0000_0200);
    rc(ADDR_IRQ, 32'h0000_0004);
    wr(ADDR_MASK, 32'h0000_000B);
    gap();
    `CHK(irq, 1'b0)
    wr(ADDR_MASK, 32'h0000_000F);
    gap();
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ, 32'h0000_0004);
    gap();
    `CHK(irq, 1'b0)
    $display("test block and chain done");
    wrap_up();
  end
endmodule // data_transfer_mode_engine_test
bind dtm_engine dtm_checker u_chk (.clock, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .mem_req, .mem_we, .mem_word, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
`default_nettype wire
